// ==== logic/otptl_consts.vh ====
`ifndef OTPTL_CONSTS_VH
`define OTPTL_CONSTS_VH

// Fuse array geometry
`define OTPTL_ARRAY_BITS 128
`define OTPTL_WORD_W 8
`define OTPTL_WORDS 16
`define OTPTL_ADDR_W 4

// Field layout inside the 128-bit image
`define OTPTL_CRIT_LSB 0
`define OTPTL_CRIT_W 86
`define OTPTL_CRC_LSB 86
`define OTPTL_CRC_W 3
`define OTPTL_AUX_LSB 89
`define OTPTL_AUX_W 18
`define OTPTL_TRACE_LSB 107
`define OTPTL_TRACE_W 20
`define OTPTL_DEBUG_BIT 127

// CRC defaults (x^3 + x + 1, zero seed, first critical bit fed first)
`define OTPTL_CRC_POLY 3'h3
`define OTPTL_CRC_INIT 3'h0
`define OTPTL_CRC_LSB_FIRST 1'h1

// Fault status layout and reset value
`define OTPTL_FLT_W 8
`define OTPTL_FLT_CRC_BIT 0
`define OTPTL_FLT_RESET 8'h00

`endif

// ==== logic/otptl_fuse_mem.v ====
`timescale 1ns/1ps
`include "otptl_consts.vh"

// Fuse array: 16 words of 8 bits; a blown bit never returns to zero
module otptl_fuse_mem #(
    parameter [`OTPTL_ARRAY_BITS-1:0] FUSE_IMAGE = 128'h0
) (
    // Clock
    input wire clk,
    // Access port
    input wire rd_en,
    input wire wr_en,
    input wire [`OTPTL_ADDR_W-1:0] addr,
    input wire [`OTPTL_WORD_W-1:0] wdata,
    output reg [`OTPTL_WORD_W-1:0] rdata_reg
);

    reg [`OTPTL_WORD_W-1:0] blown_mem [0:`OTPTL_WORDS-1];
    wire [`OTPTL_ARRAY_BITS-1:0] image_w = FUSE_IMAGE;
    integer i;

    // Virgin fuses at power-up; blown bits are non-volatile in silicon
    initial begin
        for (i = 0; i < `OTPTL_WORDS; i = i + 1) begin
            blown_mem[i] = 8'h00;
        end
    end

    // Programming can only add ones, as a real fuse would
    always @(posedge clk) begin
        if (wr_en) begin
            blown_mem[addr] <= blown_mem[addr] | wdata;
        end
        if (rd_en) begin
            rdata_reg <= blown_mem[addr] | image_w[addr*`OTPTL_WORD_W +: `OTPTL_WORD_W];
        end
    end

endmodule

// ==== logic/otptl_loader.v ====
// Summary of operation
// - A 128-bit one-time programmable array holds all trim and identity data.
// - Bits 0-85 are critical trims; bits 86-88 hold their expected CRC.
// - Bits 89-106 trim non-critical blocks and are outside the CRC.
// - Bits 107-126 identify die and wafer and go to no circuit.
// - Bit 127 is a spare debug bit outside all other groups.
// - Host array access is refused unless production test mode is active.
// - After every power-on reset the array is read and trims delivered.
// - The CRC over critical bits is computed and compared while loading.
// - A CRC mismatch sets the CRC failure flag in the fault status.
`timescale 1ns/1ps
`include "otptl_consts.vh"

module otptl_loader #(
    parameter [`OTPTL_CRC_W-1:0] CRC_POLY = `OTPTL_CRC_POLY,
    parameter [`OTPTL_CRC_W-1:0] CRC_INIT = `OTPTL_CRC_INIT,
    parameter CRC_LSB_FIRST = `OTPTL_CRC_LSB_FIRST,
    parameter [`OTPTL_ARRAY_BITS-1:0] FUSE_IMAGE = 128'h0
) (
    // Clock and power-on reset
    input wire SYS_CLK,
    input wire RESET_N,
    // Production test mode pin
    input wire TEST_MODE_EN,
    // Host access from the serial interface logic
    input wire HOST_REQ,
    input wire HOST_WR,
    input wire [`OTPTL_ADDR_W-1:0] HOST_ADDR,
    input wire [`OTPTL_WORD_W-1:0] HOST_WDATA,
    output reg [`OTPTL_WORD_W-1:0] HOST_RDATA,
    output reg HOST_ACK,
    output reg HOST_REFUSED,
    // Fault status
    input wire FAULT_CLR,
    output reg [`OTPTL_FLT_W-1:0] FAULT_STATUS,
    // Trim delivery
    output reg [`OTPTL_CRIT_W-1:0] CRIT_TRIM,
    output reg [`OTPTL_AUX_W-1:0] AUX_TRIM,
    output reg DEBUG_BIT,
    output reg LOAD_DONE
);

    localparam [1:0] ST_READ = 2'h0;
    localparam [1:0] ST_CRC = 2'h1;
    localparam [1:0] ST_CHECK = 2'h2;
    localparam [1:0] ST_RUN = 2'h3;
    localparam [6:0] CRIT_LAST = `OTPTL_CRIT_W - 1;
    localparam [4:0] WORDS_N = `OTPTL_WORDS;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [4:0] rd_cnt_reg;
    reg [`OTPTL_ADDR_W-1:0] cap_idx_reg;
    reg cap_vld_reg;
    reg [`OTPTL_ARRAY_BITS-1:0] shadow_reg;
    reg [6:0] crc_cnt_reg;
    reg [`OTPTL_CRC_W-1:0] crc_reg;
    reg [`OTPTL_CRC_W-1:0] crc_next;
    reg tm_meta_reg;
    reg tm_sync_reg;
    reg host_pend_reg;
    reg mem_rd_en;
    reg mem_wr_en;
    reg [`OTPTL_ADDR_W-1:0] mem_addr;
    reg crc_bit;
    wire [`OTPTL_WORD_W-1:0] mem_rdata;
    wire host_ok;
    wire [6:0] bit_idx;

    // Test mode pin passes two flops; only the second is read
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tm_meta_reg <= 1'b0;
            tm_sync_reg <= 1'b0;
        end else begin
            tm_meta_reg <= TEST_MODE_EN;
            tm_sync_reg <= tm_meta_reg;
        end
    end

    assign host_ok = tm_sync_reg && (state_reg == ST_RUN) && !host_pend_reg;

    // Fuse array port: loader owns it until the load ends, then the host
    always @* begin
        mem_rd_en = 1'b0;
        mem_wr_en = 1'b0;
        mem_addr = HOST_ADDR;
        if (state_reg == ST_READ) begin
            mem_rd_en = (rd_cnt_reg < WORDS_N);
            mem_addr = rd_cnt_reg[`OTPTL_ADDR_W-1:0];
        end else if (HOST_REQ && host_ok) begin
            mem_rd_en = !HOST_WR;
            mem_wr_en = HOST_WR;
        end
    end

    otptl_fuse_mem #(
        .FUSE_IMAGE(FUSE_IMAGE)
    ) u_fuse (
        .clk(SYS_CLK),
        .rd_en(mem_rd_en),
        .wr_en(mem_wr_en),
        .addr(mem_addr),
        .wdata(HOST_WDATA),
        .rdata_reg(mem_rdata)
    );

    assign bit_idx = CRC_LSB_FIRST ? crc_cnt_reg : (CRIT_LAST - crc_cnt_reg);

    // serial CRC, one critical bit per clock
    always @* begin
        crc_bit = shadow_reg[bit_idx] ^ crc_reg[`OTPTL_CRC_W-1];
        crc_next = {crc_reg[`OTPTL_CRC_W-2:0], 1'b0};
        if (crc_bit) begin
            crc_next = crc_next ^ CRC_POLY;
        end
    end

    // Load sequencer; one pass per power-on reset, then parked in ST_RUN
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_READ: begin
                if (cap_vld_reg && cap_idx_reg == WORDS_N[`OTPTL_ADDR_W-1:0] - 4'h1) begin
                    state_next = ST_CRC;
                end
            end
            ST_CRC: begin
                if (crc_cnt_reg == CRIT_LAST) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: state_next = ST_RUN;
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_READ;
        endcase
    end

    // Sequencer registers and image capture
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= ST_READ;
            rd_cnt_reg <= 5'h00;
            cap_idx_reg <= 4'h0;
            cap_vld_reg <= 1'b0;
            shadow_reg <= 128'h0;
            crc_cnt_reg <= 7'h00;
            crc_reg <= CRC_INIT;
        end else begin
            state_reg <= state_next;
            cap_vld_reg <= (state_reg == ST_READ) && mem_rd_en;
            cap_idx_reg <= rd_cnt_reg[`OTPTL_ADDR_W-1:0];
            if (state_reg == ST_READ && rd_cnt_reg < WORDS_N) begin
                rd_cnt_reg <= rd_cnt_reg + 5'h01;
            end
            // Word k of the array lands in image bits 8k+7..8k
            if (cap_vld_reg) begin
                shadow_reg[cap_idx_reg*`OTPTL_WORD_W +: `OTPTL_WORD_W] <= mem_rdata;
            end
            if (state_reg == ST_CRC) begin
                crc_reg <= crc_next;
                crc_cnt_reg <= crc_cnt_reg + 7'h01;
            end
        end
    end

    // Trim delivery, written once at the end of the load
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CRIT_TRIM <= 86'h0;
            AUX_TRIM <= 18'h0;
            DEBUG_BIT <= 1'b0;
            LOAD_DONE <= 1'b0;
        end else if (state_reg == ST_CHECK) begin
            CRIT_TRIM <= shadow_reg[`OTPTL_CRIT_LSB +: `OTPTL_CRIT_W];
            AUX_TRIM <= shadow_reg[`OTPTL_AUX_LSB +: `OTPTL_AUX_W];
            DEBUG_BIT <= shadow_reg[`OTPTL_DEBUG_BIT];
            LOAD_DONE <= 1'b1;
        end
        // no other path writes trims; host fuse writes do not reach them
        // traceability bits stay in the array only
    end

    // Fault status; a mismatch in the clear cycle still sets the flag
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FAULT_STATUS <= `OTPTL_FLT_RESET;
        end else begin
            if (state_reg == ST_CHECK && crc_reg != shadow_reg[`OTPTL_CRC_LSB +: `OTPTL_CRC_W]) begin
                FAULT_STATUS[`OTPTL_FLT_CRC_BIT] <= 1'b1;
            end else if (FAULT_CLR) begin
                FAULT_STATUS[`OTPTL_FLT_CRC_BIT] <= 1'b0;
            end
        end
    end

    // Host answers: ack two clocks after the request, refusal one clock after
    always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            host_pend_reg <= 1'b0;
            HOST_ACK <= 1'b0;
            HOST_REFUSED <= 1'b0;
            HOST_RDATA <= 8'h00;
        end else begin
            host_pend_reg <= HOST_REQ && host_ok;
            HOST_ACK <= host_pend_reg;
            // refusal outside test mode, during load or while busy
            HOST_REFUSED <= HOST_REQ && !host_ok;
            if (host_pend_reg) begin
                HOST_RDATA <= mem_rdata;
            end
        end
    end

endmodule

// ==== verification/otptl_assertions.sv ====
`timescale 1ns/1ps
`include "otptl_consts.vh"

// Watches the loader pins only
module otptl_chk (
    // Clock and reset
    input wire SYS_CLK,
    input wire RESET_N,
    // Host side
    input wire TEST_MODE_EN,
    input wire HOST_REQ,
    input wire HOST_ACK,
    input wire HOST_REFUSED,
    // Status and trims
    input wire FAULT_CLR,
    input wire [`OTPTL_FLT_W-1:0] FAULT_STATUS,
    input wire [`OTPTL_CRIT_W-1:0] CRIT_TRIM,
    input wire [`OTPTL_AUX_W-1:0] AUX_TRIM,
    input wire DEBUG_BIT,
    input wire LOAD_DONE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    // Answer timing, refusals, load and fault behaviour
    ack_latency_a: assert property (HOST_ACK |-> $past(HOST_REQ, 2))
        else $error("ack not two cycles after request");
    refuse_latency_a: assert property (HOST_REFUSED |-> $past(HOST_REQ))
        else $error("refusal without request");
    early_refuse_a: assert property (HOST_REQ && !LOAD_DONE |=> HOST_REFUSED)
        else $error("request during load not refused");
    mode_refuse_a: assert property (!TEST_MODE_EN [*3] ##0 HOST_REQ |=> HOST_REFUSED)
        else $error("request outside test mode not refused");
    load_time_a: assert property ($rose(RESET_N) |-> ##[1:150] LOAD_DONE)
        else $error("load did not finish after reset");
    flag_at_check_a: assert property ($rose(FAULT_STATUS[0]) |-> $rose(LOAD_DONE))
        else $error("crc flag set outside load check");
    flag_clear_a: assert property (FAULT_CLR && LOAD_DONE |=> !FAULT_STATUS[0])
        else $error("crc flag not cleared");
    trims_hold_a: assert property ($past(LOAD_DONE) |->
        LOAD_DONE && $stable({CRIT_TRIM, AUX_TRIM, DEBUG_BIT}))
        else $error("trims moved after load");

    // Main scenarios reached
    cover property (HOST_ACK);
    cover property (HOST_REFUSED);
    cover property ($rose(FAULT_STATUS[0]));
    cover property (FAULT_CLR && FAULT_STATUS[0]);
endmodule

// ==== verification/otptl_trim_sink.sv ====
`timescale 1ns/1ps

// Trimmed circuits: keep delivered values, flag any later change
module otptl_trim_sink (
    // Clock
    input wire clk,
    // Delivered trims
    input wire done,
    input wire [85:0] crit,
    input wire [17:0] aux,
    input wire dbg,
    // Sticky, so a move in any load is seen at the end
    output reg moved = 1'b0
);
    reg [104:0] held_reg;
    reg seen_reg = 1'b0;

    always @(posedge clk) begin
        seen_reg <= done;
        if (done && !seen_reg)
            held_reg <= {crit, aux, dbg};
        if (done && seen_reg && held_reg !== {crit, aux, dbg})
            moved <= 1'b1;
    end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "otptl_consts.vh"

bind otptl_loader otptl_chk otptl_chk_i (.SYS_CLK, .RESET_N, .TEST_MODE_EN, .HOST_REQ, .HOST_ACK,
    .HOST_REFUSED, .FAULT_CLR, .FAULT_STATUS, .CRIT_TRIM, .AUX_TRIM, .DEBUG_BIT, .LOAD_DONE);

module tb;
    // Stored crc left at zero so the first load should fail the check
    localparam [127:0] IMG = {1'h1, 20'hABCDE, 18'h2A5A5, 3'h0, 86'h1234567890ABCDEF12345};
    reg clk = 1'b0, rst_n = 1'b0, tm = 1'b0, req = 1'b0, wr = 1'b0, clr = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [7:0] wd = 8'h00;
    reg [1:0] res;
    reg [2:0] crc;
    // Rows: word address beside the byte that the image holds there
    reg [11:0] rows [0:3] = '{12'h045, 12'hA01, 12'hDF5, 12'hFD5};
    wire [7:0] rdata, flt, flt2;
    wire [85:0] crit;
    wire [17:0] aux;
    wire ack, refd, dbg, done, moved, done2;
    integer n_errors = 0, cmp_count = 0, i;

    otptl_loader #(.FUSE_IMAGE(IMG)) otptl_loader_i (.SYS_CLK(clk), .RESET_N(rst_n), .TEST_MODE_EN(tm),
        .HOST_REQ(req), .HOST_WR(wr), .HOST_ADDR(adr), .HOST_WDATA(wd), .HOST_RDATA(rdata), .HOST_ACK(ack),
        .HOST_REFUSED(refd), .FAULT_CLR(clr), .FAULT_STATUS(flt), .CRIT_TRIM(crit), .AUX_TRIM(aux),
        .DEBUG_BIT(dbg), .LOAD_DONE(done));
    // Same fuses, crc fed highest critical bit first
    otptl_loader #(.CRC_LSB_FIRST(0), .FUSE_IMAGE(IMG)) otptl_loader_msb_i (.SYS_CLK(clk), .RESET_N(rst_n),
        .TEST_MODE_EN(tm), .HOST_REQ(req), .HOST_WR(wr), .HOST_ADDR(adr), .HOST_WDATA(wd), .HOST_RDATA(),
        .HOST_ACK(), .HOST_REFUSED(), .FAULT_CLR(clr), .FAULT_STATUS(flt2), .CRIT_TRIM(), .AUX_TRIM(),
        .DEBUG_BIT(), .LOAD_DONE(done2));
    otptl_trim_sink otptl_trim_sink_i (.clk(clk), .done(done), .crit(crit), .aux(aux), .dbg(dbg),
        .moved(moved));

    // 40 MHz
    always #12.5 clk = ~clk;

    // Serial crc, bit 0 first unless msb is set
    function [2:0] crc_of(input [85:0] d, input msb);
        integer k;
        begin
            crc_of = 3'h0;
            for (k = 0; k < 86; k = k + 1)
                crc_of = {crc_of[1:0], 1'h0} ^ ((d[msb ? 85 - k : k] ^ crc_of[2]) ? `OTPTL_CRC_POLY : 3'h0);
        end
    endfunction

    task chk(input [127:0] g, e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("Error at %0t: got %0h expected %0h", $time, g, e);
            end
        end
    endtask

    task end_sim;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // One access; r is {ack, refused}, bounded wait
    task acc(input w, input [3:0] a, input [7:0] d, output [1:0] r);
        integer k;
        begin
            @(posedge clk);
            req <= 1'b1;
            wr <= w;
            adr <= a;
            wd <= d;
            r = 2'h0;
            // Refusal stands only in the cycle after the taking edge, so look from there on
            for (k = 0; k < 4 && r == 2'h0; k = k + 1) begin
                @(posedge clk);
                req <= 1'b0;
                #1;
                r = {ack, refd};
            end
        end
    endtask

    task wait_load;
        integer k;
        begin
            for (k = 0; k < 200 && done !== 1'b1; k = k + 1)
                @(posedge clk);
            #1;
        end
    endtask

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #50000;
        n_errors = n_errors + 1;
        end_sim;
    end

    initial begin
        repeat (5) @(posedge clk);
        chk({done, flt}, 0);
        rst_n <= 1'b1;
        wait_load;
        crc = crc_of(IMG[85:0], 1'b0);
        chk({done, crit, aux, dbg}, {1'h1, IMG[85:0], IMG[106:89], IMG[127]});
        chk(flt, {7'h00, crc != IMG[88:86]});
        chk({done2, flt2}, {1'h1, 7'h00, crc_of(IMG[85:0], 1'b1) != IMG[88:86]});
        acc(1'b0, 4'h0, 8'h00, res);
        chk(res, 2'h1);
        // Clear pulse drops the flag one edge later
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        chk(flt, 0);
        // Row reads across every field of the array
        tm <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 4; i = i + 1) begin
            acc(1'b0, rows[i][11:8], 8'h00, res);
            chk({res, rdata}, {2'h2, rows[i][7:0]});
        end
        // Writes to words A and B, three clocks apart, blow the matching crc; trims must not follow
        acc(1'b1, 4'hA, {crc[1:0], 6'h00}, res);
        acc(1'b1, 4'hB, {7'h00, crc[2]}, res);
        chk(res, 2'h2);
        acc(1'b0, 4'hA, 8'h00, res);
        chk(rdata, IMG[87:80] | {crc[1:0], 6'h00});
        chk({crit, aux, dbg}, {IMG[85:0], IMG[106:89], IMG[127]});
        // Second power-on: early request refused, then a clean check
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, 4'h0, 8'h00, res);
        chk(res, 2'h1);
        wait_load;
        chk({done, flt}, 9'h100);
        chk({done2, flt2}, {1'h1, 7'h00, crc_of(IMG[85:0], 1'b1) != crc});
        chk({crit, moved}, {IMG[85:0], 1'h0});
        end_sim;
    end
endmodule
